// ===== verilog/cpregs_pkg.sv
// Package for the coprocessor access, power and identification register bank
package cpregs_pkg;

	// Byte addresses of the registers on the AHB-Lite window
	localparam logic [31:0] CPREGS_ADDR_POWER_S = 32'hE000E00C;
	localparam logic [31:0] CPREGS_ADDR_POWER_NS = 32'hE002E00C;
	localparam logic [31:0] CPREGS_ADDR_IDENT_S = 32'hE000ED00;
	localparam logic [31:0] CPREGS_ADDR_IDENT_NS = 32'hE002ED00;
	localparam logic [31:0] CPREGS_ADDR_ACCESS_S = 32'hE000ED88;
	localparam logic [31:0] CPREGS_ADDR_ACCESS_NS = 32'hE002ED88;
	localparam logic [31:0] CPREGS_ADDR_CONTROL = 32'hE000EF00;

	// Field positions
	localparam int CPREGS_FP_LO = 20;
	localparam int CPREGS_FP_SH_LO = 22;
	localparam int CPREGS_CTRL_STACK_SELECT = 1;
	localparam int CPREGS_CTRL_UNPRIV = 0;
	localparam int CPREGS_ID_IMPL_LO = 24;
	localparam int CPREGS_ID_VAR_LO = 20;
	localparam int CPREGS_ID_ARCH_LO = 16;
	localparam int CPREGS_ID_PART_LO = 4;

	// Writable-bit mask (coprocessor fields 0..7 plus the fp fields) and reset value
	localparam logic [31:0] CPREGS_ACCESS_MASK = 32'h00F0FFFF;
	localparam logic [31:0] CPREGS_RESET_ZERO = 32'h00000000;

	// Architecture codes for the identification register
	localparam logic [3:0] CPREGS_ARCH_MAIN = 4'h9; // Arbitrary value
	localparam logic [3:0] CPREGS_ARCH_BASE = 4'h6; // Arbitrary value

	// AHB-Lite encodings
	localparam logic [1:0] CPREGS_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CPREGS_HTRANS_SEQ = 2'h3;

	// Captured address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic priv;
		logic secure;
		logic [31:0] addr;
	} cpregs_aphase_type;

endpackage

// ===== verilog/cpregs_bank.sv
// Coprocessor access, power permission, identification and control bits behind AHB-Lite
`timescale 1ns/1ps
// How it works
// - stack_select picks main or process stack, banked
// - thread_unprivileged drops Thread privilege, banked
// - thread_unprivileged may be fixed read-as-zero
// - Unprivileged access to the access, power and identification registers faults
// - Access rights banked, present only with main extension
// - fp_access_field gates floating-point use
// - fp_access_shadow_field has no effect
// - coproc_access_field grants per-coprocessor rights
// - Missing coprocessor fields read zero; reserved zero
// - Power permission not banked, main extension only
// - fp_secure_only locks fp power bit to Secure
// - fp_state_may_lose is a power-down hint
// - Shadow power bits have no effect
// - coproc_secure_only locks coproc_state_may_lose
// - Hard-wired power bit zeroes its lock
// - Power permission bits clear on reset
// - Identification register is read-only constant
// - Implementer code in bits 31:24
// - Variant number in bits 23:20
// - Architecture code in bits 19:16
// - Part number in bits 15:4
// - Revision in bits 3:0
// - Unprivileged control writes silently ignored
module cpregs_bank
	import cpregs_pkg::*;
#(
	parameter bit MAIN_EXT = 1'b1, // Main extension present
	parameter bit FP_PRESENT = 1'b1, // Floating-point unit present
	parameter logic [7:0] CP_PRESENT = 8'h0F, // Implemented coprocessors
	parameter logic [7:0] CP_PWR_WIRED = 8'h00, // Coprocessor power bits hard-wired to zero
	parameter bit FP_PWR_WIRED = 1'b0, // Fp power bit hard-wired to zero
	parameter bit UNPRIV_RW = 1'b1, // Thread privilege bit writable without main extension
	parameter logic [7:0] IMPLEMENTER = 8'h5A, // Arbitrary value
	parameter logic [3:0] VARIANT = 4'h1, // Arbitrary value
	parameter logic [11:0] PART_NUMBER = 12'h123, // Arbitrary value
	parameter logic [3:0] REVISION = 4'h2 // Arbitrary value
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_n_i, // Warm reset, synchronous, active low
	input wire logic hsel_i, // Slave select
	input wire logic [31:0] haddr_i, // Address
	input wire logic [1:0] htrans_i, // Transfer type
	input wire logic hwrite_i, // Write strobe
	input wire logic [2:0] hsize_i, // Transfer size
	input wire logic [3:0] hprot_i, // Protection, bit 1 privileged
	input wire logic hnonsec_i, // Non-secure access
	input wire logic [31:0] hwdata_i, // Write data
	input wire logic hready_i, // Bus ready
	output logic [31:0] hrdata_o, // Read data
	output logic hreadyout_o, // Slave ready
	output logic hresp_o, // Response, always OKAY
	output logic access_fault_o, // Pulse: unprivileged access refused
	output logic stack_select_o, // Stack select of Secure state
	output logic thread_unprivileged_o, // Thread privilege of Secure state
	output logic [1:0] fp_access_s_o, // Secure fp access rights
	output logic [1:0] fp_access_ns_o, // Non-secure fp access rights
	output logic [15:0] coproc_access_s_o, // Secure coprocessor rights
	output logic [15:0] coproc_access_ns_o, // Non-secure coprocessor rights
	output logic fp_state_may_lose_o, // Fp power-down hint
	output logic [7:0] coproc_state_may_lose_o // Coprocessor power-down hints
);

	// Widen a per-coprocessor bit mask to field pairs
	function automatic logic [15:0] pair_mask(input logic [7:0] m);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[2*i] = m[i];
			r[2*i+1] = m[i];
		end
		return r;
	endfunction

	// Spread a per-coprocessor bit mask to the odd bits of field pairs, even bits zero
	function automatic logic [15:0] odd_bits(input logic [7:0] m);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[2*i+1] = m[i];
		end
		return r;
	endfunction

	cpregs_aphase_type aph; // Captured address phase
	logic [31:0] acc_s; // Secure access rights copy
	logic [31:0] acc_ns; // Non-secure access rights copy
	logic [31:0] pwr; // Power permission, shared
	logic [1:0] ctrl_s; // Secure control bits
	logic [1:0] ctrl_ns; // Non-secure control bits

	// Address phase qualification
	wire take = hsel_i & hready_i & (htrans_i == CPREGS_HTRANS_NONSEQ || htrans_i == CPREGS_HTRANS_SEQ);
	wire a_sec = aph.secure;
	wire hit_acc = (aph.addr == CPREGS_ADDR_ACCESS_S) | (aph.addr == CPREGS_ADDR_ACCESS_NS);
	wire hit_pwr = (aph.addr == CPREGS_ADDR_POWER_S) | (aph.addr == CPREGS_ADDR_POWER_NS);
	wire hit_id = (aph.addr == CPREGS_ADDR_IDENT_S) | (aph.addr == CPREGS_ADDR_IDENT_NS);
	wire hit_ctl = aph.addr == CPREGS_ADDR_CONTROL;
	// Alias addresses reach the Non-secure view only from Secure; RES0 otherwise
	wire is_alias = aph.addr[17];
	wire alias_bad = is_alias & ~a_sec;
	wire view_ns = ~a_sec | is_alias;
	// Privileged-only registers fault when unprivileged
	wire faulting = aph.valid & ~aph.priv & (hit_acc | hit_pwr | hit_id) & ~alias_bad;
	wire wr_ok = aph.valid & aph.write & aph.priv & ~alias_bad;

	// Fixed masks derived from configuration
	wire [15:0] cp_mask = MAIN_EXT ? pair_mask(CP_PRESENT) : 16'h0000;
	wire [3:0] fp_mask = (MAIN_EXT & FP_PRESENT) ? 4'hF : 4'h0;
	wire [31:0] acc_wmask = CPREGS_ACCESS_MASK & {8'h00, fp_mask, 4'h0, cp_mask};
	wire [7:0] su_impl = MAIN_EXT ? (CP_PRESENT & ~CP_PWR_WIRED) : 8'h00;
	wire fp_su_impl = MAIN_EXT & FP_PRESENT & ~FP_PWR_WIRED;
	wire [15:0] pwr_cp_mask = pair_mask(su_impl);
	wire [31:0] pwr_wmask = {8'h00, {4{fp_su_impl}}, 4'h0, pwr_cp_mask};

	// Non-secure writable bits: secure-only bits never, locked power bits never
	wire [7:0] su_lock;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_lock
			assign su_lock[g] = pwr[2*g+1];
		end
	endgenerate
	wire [15:0] ns_cp_open = pair_mask(~su_lock) & ~odd_bits(8'hFF);
	wire fp_open = ~pwr[CPREGS_FP_LO+1];
	wire [31:0] pwr_ns_mask = {8'h00, 1'b0, fp_open, 1'b0, fp_open, 4'h0, ns_cp_open};
	wire [31:0] pwr_view = view_ns ? (pwr & pwr_ns_mask) : pwr;

	// Identification constant
	wire [3:0] arch_code = MAIN_EXT ? CPREGS_ARCH_MAIN : CPREGS_ARCH_BASE;
	wire [31:0] ident = {IMPLEMENTER, VARIANT, arch_code, PART_NUMBER, REVISION};

	// Control bits of the viewed state
	wire [1:0] ctrl_view = view_ns ? ctrl_ns : ctrl_s;
	wire unpriv_ok = MAIN_EXT | UNPRIV_RW;
	wire [1:0] ctrl_wmask = {1'b1, unpriv_ok};

	// Read data multiplexer
	wire [31:0] rd_acc = (view_ns ? acc_ns : acc_s) & acc_wmask;
	wire [31:0] rd_val = (alias_bad | ~aph.priv) ? 32'h00000000 :
		hit_acc ? rd_acc :
		hit_pwr ? pwr_view :
		hit_id ? ident :
		hit_ctl ? {30'h00000000, ctrl_view} : 32'h00000000;

	// Capture the address phase whenever the bus is ready
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			aph <= '0;
		end else if (hready_i) begin
			aph <= '{valid: take, write: hwrite_i, priv: hprot_i[1], secure: ~hnonsec_i, addr: haddr_i};
		end
	end

	// Access rights copies; implemented fields reset unknown, zero chosen here
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			acc_s <= CPREGS_RESET_ZERO;
			acc_ns <= CPREGS_RESET_ZERO;
		end else if (wr_ok && hit_acc) begin
			if (view_ns) begin
				acc_ns <= hwdata_i & acc_wmask;
			end else begin
				acc_s <= hwdata_i & acc_wmask;
			end
		end
	end

	// Power permission, one shared copy
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pwr <= CPREGS_RESET_ZERO;
		end else if (wr_ok && hit_pwr) begin
			if (view_ns) begin
				pwr <= (pwr & ~(pwr_wmask & pwr_ns_mask)) | (hwdata_i & pwr_wmask & pwr_ns_mask);
			end else begin
				pwr <= hwdata_i & pwr_wmask;
			end
		end
	end

	// Control bits; unprivileged writes dropped without fault
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_s <= 2'h0;
			ctrl_ns <= 2'h0;
		end else if (wr_ok && hit_ctl) begin
			if (view_ns) begin
				ctrl_ns <= hwdata_i[1:0] & ctrl_wmask;
			end else begin
				ctrl_s <= hwdata_i[1:0] & ctrl_wmask;
			end
		end
	end

	// Bus answer and registered outputs; reads take one wait state so that the
	// registered read data stands in the last data-phase cycle, writes take none
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			access_fault_o <= 1'b0;
			stack_select_o <= 1'b0;
			thread_unprivileged_o <= 1'b0;
			fp_access_s_o <= 2'h0;
			fp_access_ns_o <= 2'h0;
			coproc_access_s_o <= 16'h0000;
			coproc_access_ns_o <= 16'h0000;
			fp_state_may_lose_o <= 1'b0;
			coproc_state_may_lose_o <= 8'h00;
		end else begin
			hrdata_o <= rd_val;
			hreadyout_o <= ~(take & ~hwrite_i); // Wait state after a read address phase
			hresp_o <= 1'b0;
			access_fault_o <= faulting & hready_i;
			stack_select_o <= ctrl_s[CPREGS_CTRL_STACK_SELECT];
			thread_unprivileged_o <= ctrl_s[CPREGS_CTRL_UNPRIV];
			fp_access_s_o <= acc_s[CPREGS_FP_LO+:2] & fp_mask[1:0];
			fp_access_ns_o <= acc_ns[CPREGS_FP_LO+:2] & fp_mask[1:0];
			coproc_access_s_o <= acc_s[15:0] & cp_mask;
			coproc_access_ns_o <= acc_ns[15:0] & cp_mask;
			fp_state_may_lose_o <= pwr[CPREGS_FP_LO];
			coproc_state_may_lose_o <= {pwr[14], pwr[12], pwr[10], pwr[8], pwr[6], pwr[4], pwr[2], pwr[0]};
		end
	end

endmodule

// ===== verification/cpregs_properties.sv
// Port checker of the coprocessor register bank
`timescale 1ns/1ps
module cpregs_properties
	import cpregs_pkg::*;
(
	input wire logic clk_sys_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic hsel_i, // Select
	input wire logic [31:0] haddr_i, // Address
	input wire logic [1:0] htrans_i, // Transfer type
	input wire logic hwrite_i, // Write
	input wire logic [3:0] hprot_i, // Protection
	input wire logic hready_i, // Ready
	input wire logic access_fault_o, // Fault pulse
	input wire logic stack_select_o, // Stack select
	input wire logic thread_unprivileged_o, // Thread privilege
	input wire logic [1:0] fp_access_s_o, // Secure fp rights
	input wire logic [15:0] coproc_access_s_o, // Secure rights
	input wire logic [15:0] coproc_access_ns_o, // Non-secure rights
	input wire logic fp_state_may_lose_o, // Fp hint
	input wire logic [7:0] coproc_state_may_lose_o // Coprocessor hints
);
	wire take = hsel_i && hready_i && htrans_i[1]; // Address phase taken
	wire pw = take && hwrite_i && hprot_i[1]; // Privileged write
	wire hit = haddr_i == CPREGS_ADDR_ACCESS_S || haddr_i == CPREGS_ADDR_POWER_S || haddr_i == CPREGS_ADDR_IDENT_S;
	wire flt = take && !hprot_i[1] && hit; // Access that must fault
	logic [2:0] wa, wp, wc; // Recent writes; outputs lag a write by up to three edges
	// Write history per register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wa <= 3'h0;
			wp <= 3'h0;
			wc <= 3'h0;
		end else begin
			wa <= {wa[1:0], pw && haddr_i[15:0] == 16'hED88};
			wp <= {wp[1:0], pw && haddr_i[15:0] == 16'hE00C};
			wc <= {wc[1:0], pw && haddr_i[15:0] == 16'hEF00};
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_fault_on_unpriv: assert property (flt |-> ##[2:3] access_fault_o)
		else $error("no fault on unprivileged access");
	a_fault_has_cause: assert property (access_fault_o |-> $past(flt, 2) || $past(flt, 3))
		else $error("fault without cause");
	a_ctrl_after_reset: assert property ($rose(rst_n_i) |-> !stack_select_o && !thread_unprivileged_o)
		else $error("control bits not cleared");
	a_hint_after_reset: assert property ($rose(rst_n_i) |-> !fp_state_may_lose_o && coproc_state_may_lose_o == 8'h00)
		else $error("power hints not cleared");
	a_absent_cp_zero: assert property (coproc_access_s_o[15:8] == 8'h00 && coproc_access_ns_o[15:8] == 8'h00)
		else $error("absent coprocessor rights set");
	a_rights_held: assert property (wa == 3'h0 |-> $stable(fp_access_s_o) && $stable(coproc_access_s_o))
		else $error("rights changed without write");
	a_power_held: assert property (wp == 3'h0 |-> $stable(fp_state_may_lose_o) && $stable(coproc_state_may_lose_o))
		else $error("hints changed without write");
	a_ctrl_held: assert property (wc == 3'h0 |-> $stable(stack_select_o) && $stable(thread_unprivileged_o))
		else $error("control changed without write");
	c_fault: cover property (access_fault_o);
	c_hint: cover property (fp_state_may_lose_o);
	c_ctrl: cover property (stack_select_o && thread_unprivileged_o);
endmodule
bind cpregs_bank cpregs_properties chk_u (.clk_sys_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hprot_i,
	.hready_i, .access_fault_o, .stack_select_o, .thread_unprivileged_o, .fp_access_s_o, .coproc_access_s_o,
	.coproc_access_ns_o, .fp_state_may_lose_o, .coproc_state_may_lose_o);

// ===== verification/cpregs_bank_test.sv
// Self-checking bench of the coprocessor register bank
`timescale 1ns/1ps
module cpregs_bank_test
	import cpregs_pkg::*;
;
	localparam logic [31:0] ID = {8'h3C, 4'h1, CPREGS_ARCH_MAIN, 12'h9A5, 4'h2}; // Arbitrary identity
	logic clk_sys_i = 1'b0; // Clock
	logic rst_n_i = 1'b0; // Reset
	cpregs_aphase_type ap = '0; // Address phase drive
	logic [31:0] hwdata = 32'h0; // Write data
	logic [31:0] lfsr_q = 32'h0E40; // Random state
	logic [31:0] rd, d, w, s; // Read data and expectations
	int error_cnt = 0;
	int check_count = 0;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, fault, ssel, tunp, fph;
	wire logic [1:0] fps, fpn;
	wire logic [15:0] cps, cpn;
	wire logic [7:0] cph;
	always #2 clk_sys_i = ~clk_sys_i;
	cpregs_bank #(.IMPLEMENTER(8'h3C), .PART_NUMBER(12'h9A5)) dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.hsel_i(ap.valid), .haddr_i(ap.addr), .htrans_i(ap.valid ? CPREGS_HTRANS_NONSEQ : 2'h0),
		.hwrite_i(ap.write), .hsize_i(3'h2), .hprot_i({2'h0, ap.priv, 1'b1}), .hnonsec_i(!ap.secure),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.access_fault_o(fault), .stack_select_o(ssel), .thread_unprivileged_o(tunp), .fp_access_s_o(fps),
		.fp_access_ns_o(fpn), .coproc_access_s_o(cps), .coproc_access_ns_o(cpn), .fp_state_may_lose_o(fph),
		.coproc_state_may_lose_o(cph));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Power bits a Non-secure write may change: unlocked ones only
	function automatic logic [31:0] ns_wr(input logic [31:0] v, input logic [31:0] x);
		logic [31:0] r;
		r = v;
		for (int m = 0; m < 8; m++)
			if (!v[2*m+1]) r[2*m] = x[2*m];
		if (!v[21]) {r[22], r[20]} = {x[22], x[20]};
		return r & 32'h00F000FF;
	endfunction
	// Non-secure view hides lock bits and locked power bits
	function automatic logic [31:0] ns_view(input logic [31:0] v);
		return v & (v ^ ns_wr(v, ~v)) & 32'h0050_5555;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One single word transfer; read data stands in the last data-phase cycle
	task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd, input logic pv, input logic ns);
		ap <= '{1'b1, wr, pv, !ns, a};
		@(posedge clk_sys_i);
		while (hready !== 1'b1) @(posedge clk_sys_i);
		ap <= '0;
		hwdata <= wd;
		@(posedge clk_sys_i);
		while (hready !== 1'b1) @(posedge clk_sys_i);
		rd = hrdata;
		@(posedge clk_sys_i);
	endtask
	task automatic final_report();
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Reset, then walk through every register and view; control bits are read back in the Secure view only, identification in the Non-secure one
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		chk({fph, cph, ssel, tunp, cps, cpn[3:0]}, 32'h0);
		bus(CPREGS_ADDR_IDENT_S, 1'b1, lfsr_q, 1'b1, 1'b0);
		bus(CPREGS_ADDR_IDENT_S, 1'b0, 32'h0, 1'b1, 1'b1);
		chk(rd, ID);
		bus(CPREGS_ADDR_IDENT_NS, 1'b0, 32'h0, 1'b1, 1'b1);
		chk(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			lfsr_q = nxt(lfsr_q);
			d = {lfsr_q[31:22], i[1:0], lfsr_q[19:2], i[2:1]};
			bus(CPREGS_ADDR_ACCESS_S, 1'b1, d, 1'b1, 1'b0);
			bus(CPREGS_ADDR_ACCESS_S, 1'b1, ~d, 1'b1, 1'b1);
			bus(CPREGS_ADDR_ACCESS_S, 1'b0, 32'h0, 1'b1, 1'b0);
			chk(rd, d & 32'h00F000FF);
			bus(CPREGS_ADDR_ACCESS_NS, 1'b0, 32'h0, 1'b1, 1'b0);
			chk(rd, ~d & 32'h00F000FF);
			chk({fpn, cpn, fps, cps[7:0]}, {~d[21:20], 8'h0, ~d[7:0], d[21:20], d[7:0]});
		end
		bus(CPREGS_ADDR_ACCESS_S, 1'b1, 32'h0, 1'b0, 1'b0);
		bus(CPREGS_ADDR_ACCESS_S, 1'b0, 32'h0, 1'b0, 1'b0);
		chk(rd, 32'h0);
		bus(CPREGS_ADDR_ACCESS_S, 1'b0, 32'h0, 1'b1, 1'b0);
		chk(rd, d & 32'h00F000FF);
		for (int i = 0; i < 4; i++) begin
			lfsr_q = nxt(lfsr_q);
			s = (i == 0) ? 32'h00F000FF : lfsr_q & 32'h00F000FF;
			w = ~lfsr_q;
			bus(CPREGS_ADDR_POWER_S, 1'b1, s, 1'b1, 1'b0);
			bus(CPREGS_ADDR_POWER_S, 1'b1, w, 1'b1, 1'b1);
			s = ns_wr(s, w);
			bus(CPREGS_ADDR_POWER_S, 1'b0, 32'h0, 1'b1, 1'b1);
			chk(rd, ns_view(s));
			bus(CPREGS_ADDR_POWER_NS, 1'b0, 32'h0, 1'b1, 1'b0);
			chk(rd, ns_view(s));
			bus(CPREGS_ADDR_POWER_S, 1'b0, 32'h0, 1'b1, 1'b0);
			chk(rd, s);
			chk({fph, cph}, {s[20], s[14], s[12], s[10], s[8], s[6], s[4], s[2], s[0]});
		end
		bus(CPREGS_ADDR_CONTROL, 1'b1, 32'h3, 1'b1, 1'b0);
		bus(CPREGS_ADDR_CONTROL, 1'b1, 32'h0, 1'b0, 1'b0);
		bus(CPREGS_ADDR_CONTROL, 1'b1, 32'h0, 1'b1, 1'b1);
		bus(CPREGS_ADDR_CONTROL, 1'b0, 32'h0, 1'b1, 1'b0);
		chk({rd[1:0], ssel, tunp}, 4'hF);
		bus(32'hE000ED04, 1'b0, 32'h0, 1'b1, 1'b0);
		chk(rd, 32'h0);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		bus(CPREGS_ADDR_POWER_S, 1'b0, 32'h0, 1'b1, 1'b0);
		chk(rd, 32'h0);
		chk({fph, ssel, tunp}, 32'h0);
		chk({hresp, hready}, 32'h1);
		final_report();
	end
	// Cut a hang short
	initial begin
		#20000;
		error_cnt++;
		final_report();
	end
endmodule
